//--- timer_pair_defines.svh
// register offsets, field positions and counts for the counter/timer pair
// assumes an 8-bit APB byte address, one 32-bit word per register
`ifndef TIMER_PAIR_DEFINES_SVH
`define TIMER_PAIR_DEFINES_SVH

// register byte addresses
`define OFF_CTRL    8'h00
`define OFF_MODE    8'h04
`define OFF_CLKC    8'h08
`define OFF_IMASK   8'h0C
`define OFF_EXTCFG  8'h10
`define OFF_TL0     8'h14
`define OFF_TH0     8'h18
`define OFF_TL1     8'h1C
`define OFF_TH1     8'h20
`define OFF_ISTAT   8'h24
`define OFF_ICLR    8'h28

// bit positions, i is the timer number
`define CTRL_TR(i)  (4 + 2 * (i))
`define CTRL_TF(i)  (5 + 2 * (i))
`define MODE_LO(i)  (4 * (i))
`define MODE_CT(i)  (4 * (i) + 2)
`define MODE_GT(i)  (4 * (i) + 3)
`define CLK_SYS(i)  (3 + (i))
`define IRQ_BIT(i)  (1 + 2 * (i))
`define EXT_PL(i)   (3 + 4 * (i))

// writable bits of sparse registers
`define CLKC_MASK   8'h1B
`define IMASK_MASK  8'h0A
`define EXTCFG_MASK 8'h88

// prescaler: one counter wraps at 48 and serves every divisor
`define PRE_WRAP    6'h2F
`define PRE_DIV12   6'h0C
`define PRE_LAST12  6'h0B
`define PRE_LAST8   3'h7
`define PRE_LAST4   2'h3

`define BYTE_ONES   8'hFF
`define LOW5_ONES   5'h1F
`define RESET_BYTE  8'h00

`endif

//--- timer_pair_pkg.sv
// types shared by the counter/timer pair
// assumes the defines header for field positions
package timer_pair_pkg;

  // two-bit mode field of each timer
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'h0,
    MODE_16BIT  = 2'h1,
    MODE_8RELOAD = 2'h2,
    MODE_SPLIT  = 2'h3
  } tmode_t;

  // prescaler divisor choice
  typedef enum logic [1:0] {
    SCALE_12 = 2'h0,
    SCALE_4  = 2'h1,
    SCALE_48 = 2'h2,
    SCALE_8  = 2'h3
  } scale_t;

endpackage : timer_pair_pkg

//--- timer_pair.sv
// two 16-bit counter/timers with 13-bit, 16-bit and 8-bit reload modes
// assumes an APB master on pclk and asynchronous event and gate pins
//
// What this block does
// - each timer clocks from the system clock or a prescaled clock chosen by a shared two-bit scale field.
// - in counter use each sampled falling edge of the event pin adds one, up to a quarter of pclk.
// - each count is 16 bits reached as a separate low and high byte register.
// - a two-bit field per timer in the mode register picks its mode on its own.
// - in 13-bit mode the high byte holds the top eight bits and low bits 4..0 the bottom five.
// - rolling the 13-bit count from all ones to zero sets the overflow flag and may interrupt.
// - count select 1 counts pin falling edges, 0 uses pclk or the prescaled clock per the select bit.
// - a timer advances only with its run bit set and either gating off or its gate pin active.
// - setting the run bit keeps the present count.
// - timer one mirrors timer zero with its own bits and the second gate pin and polarity.
// - 16-bit mode uses all sixteen bits with the same enabling and overflow handling.
// - 8-bit reload mode counts the low byte and on rollover sets the flag and copies the high byte in.
// - an overflow interrupts only when that timer's enable bit is set.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "timer_pair_defines.svh"

module timer_pair
  import timer_pair_pkg::*;
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // event and gate pins
  input  wire logic        timer_zero_event_pin,
  input  wire logic        timer_one_event_pin,
  input  wire logic        ext_irq_zero_pin,
  input  wire logic        ext_irq_one_pin,
  // interrupt acknowledge pulses
  input  wire logic        timer_zero_irq_ack,
  input  wire logic        timer_one_irq_ack,
  // interrupt requests
  output logic             timer_zero_irq,
  output logic             timer_one_irq,
  output logic             irq
);

  // bus state
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        xfer;
  logic        wr;
  logic        mapped;
  logic [7:0]  rd_byte;
  // shared configuration
  logic [1:0]  tr_r;
  logic [7:0]  timer_mode_register_r;
  logic [7:0]  clock_control_register_r;
  logic [7:0]  interrupt_mask_register_r;
  logic [7:0]  ext_irq_config_register_r;
  // per timer state
  logic [7:0]  tl_r [2];
  logic [7:0]  th_r [2];
  logic        tf_r [2];
  logic        adv [2];
  logic        ovf [2];
  logic [1:0]  ack;
  logic [1:0]  ev_pin;
  logic [1:0]  gt_pin;
  // prescaler
  logic [5:0]  pre_r;
  logic        pre_tick;

  assign ack    = {timer_one_irq_ack, timer_zero_irq_ack};
  assign ev_pin = {timer_one_event_pin, timer_zero_event_pin};
  assign gt_pin = {ext_irq_one_pin, ext_irq_zero_pin};
  assign xfer = psel && penable && pready_r;
  assign wr   = xfer && pwrite;

  // one hit decode shared by every register write
  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = wr && (paddr == off);
  endfunction : wr_hit
  // prescaler taps from one mod-48 counter
  function automatic logic pre_hit(input logic [1:0] sca,
                                   input logic [5:0] cnt);
    unique case (scale_t'(sca))
      SCALE_12: pre_hit = ((cnt % `PRE_DIV12) == `PRE_LAST12);
      SCALE_4:  pre_hit = (cnt[1:0] == `PRE_LAST4);
      SCALE_48: pre_hit = (cnt == `PRE_WRAP);
      SCALE_8:  pre_hit = (cnt[2:0] == `PRE_LAST8);
    endcase
  endfunction : pre_hit

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 6'h00;
    end else if (pre_r == `PRE_WRAP) begin
      pre_r <= 6'h00;
    end else begin
      pre_r <= pre_r + 6'h01;
    end
  end

  assign pre_tick = pre_hit(clock_control_register_r[1:0], pre_r);

  // configuration registers; unused bits masked so they read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_register_r     <= `RESET_BYTE;
      clock_control_register_r  <= `RESET_BYTE;
      interrupt_mask_register_r <= `RESET_BYTE;
      ext_irq_config_register_r <= `RESET_BYTE;
    end else begin
      if (wr_hit(`OFF_MODE)) timer_mode_register_r <= pwdata[7:0];
      if (wr_hit(`OFF_CLKC))
        clock_control_register_r <= pwdata[7:0] & `CLKC_MASK;
      if (wr_hit(`OFF_IMASK))
        interrupt_mask_register_r <= pwdata[7:0] & `IMASK_MASK;
      if (wr_hit(`OFF_EXTCFG))
        ext_irq_config_register_r <= pwdata[7:0] & `EXTCFG_MASK;
    end
  end

  // one generate slice per timer; timer one is the same logic
  for (genvar i = 0; i < 2; i++) begin : g_tmr
    localparam logic [7:0] TL_OFF = (i == 0) ? `OFF_TL0 : `OFF_TL1;
    localparam logic [7:0] TH_OFF = (i == 0) ? `OFF_TH0 : `OFF_TH1;
    logic        ev_s1, ev_s2, ev_s3;
    logic        gt_s1, gt_s2;
    logic        ev_fall;
    logic        run_ok;
    logic        tick;
    logic [12:0] c13;
    tmode_t      md;

    // pins pass two flops before use; the third flop is edge history
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ev_s1 <= 1'b1;
        ev_s2 <= 1'b1;
        ev_s3 <= 1'b1;
        gt_s1 <= 1'b0;
        gt_s2 <= 1'b0;
      end else begin
        ev_s1 <= ev_pin[i];
        ev_s2 <= ev_s1;
        ev_s3 <= ev_s2;
        gt_s1 <= gt_pin[i];
        gt_s2 <= gt_s1;
      end
    end

    assign ev_fall = ev_s3 && !ev_s2;
    assign md = tmode_t'(timer_mode_register_r[`MODE_LO(i) +: 2]);
    assign run_ok = tr_r[i] && (!timer_mode_register_r[`MODE_GT(i)] ||
        (gt_s2 == ext_irq_config_register_r[`EXT_PL(i)]));
    assign tick = timer_mode_register_r[`MODE_CT(i)] ? ev_fall :
        (clock_control_register_r[`CLK_SYS(i)] ? 1'b1 : pre_tick);
    // split mode is not built here, so a timer in it holds still
    assign adv[i] = run_ok && tick && (md != MODE_SPLIT);
    assign c13 = {th_r[i], tl_r[i][4:0]} + 13'h0001;

    always_comb begin
      unique case (md)
        MODE_13BIT:   ovf[i] = adv[i] &&
            (tl_r[i][4:0] == `LOW5_ONES) && (th_r[i] == `BYTE_ONES);
        MODE_16BIT:   ovf[i] = adv[i] &&
            (tl_r[i] == `BYTE_ONES) && (th_r[i] == `BYTE_ONES);
        MODE_8RELOAD: ovf[i] = adv[i] && (tl_r[i] == `BYTE_ONES);
        MODE_SPLIT:   ovf[i] = 1'b0;
      endcase
    end

    // count is never cleared by the run bit, only by reset or writes
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tl_r[i] <= `RESET_BYTE;
      end else if (wr_hit(TL_OFF)) begin
        tl_r[i] <= pwdata[7:0];
      end else if (adv[i]) begin
        unique case (md)
          MODE_13BIT:   tl_r[i][4:0] <= c13[4:0];
          MODE_16BIT:   tl_r[i] <= tl_r[i] + 8'h01;
          MODE_8RELOAD: tl_r[i] <= ovf[i] ? th_r[i] : tl_r[i] + 8'h01;
          MODE_SPLIT:   tl_r[i] <= tl_r[i];
        endcase
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        th_r[i] <= `RESET_BYTE;
      end else if (wr_hit(TH_OFF)) begin
        th_r[i] <= pwdata[7:0];
      end else if (adv[i]) begin
        unique case (md)
          MODE_13BIT:   th_r[i] <= c13[12:5];
          MODE_16BIT:   if (tl_r[i] == `BYTE_ONES) th_r[i] <= th_r[i] + 8'h01;
          MODE_8RELOAD: th_r[i] <= th_r[i];
          MODE_SPLIT:   th_r[i] <= th_r[i];
        endcase
      end
    end

    // overflow beats any clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tf_r[i] <= 1'b0;
      end else if (ovf[i]) begin
        tf_r[i] <= 1'b1;
      end else if (ack[i] || (wr_hit(`OFF_ICLR) && pwdata[`IRQ_BIT(i)])) begin
        tf_r[i] <= 1'b0;
      end else if (wr_hit(`OFF_CTRL)) begin
        tf_r[i] <= pwdata[`CTRL_TF(i)];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tr_r[i] <= 1'b0;
      end else if (wr_hit(`OFF_CTRL)) begin
        tr_r[i] <= pwdata[`CTRL_TR(i)];
      end
    end
  end

  // interrupt outputs, one cycle behind the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_zero_irq <= 1'b0;
      timer_one_irq  <= 1'b0;
      irq            <= 1'b0;
    end else begin
      timer_zero_irq <= tf_r[0] && interrupt_mask_register_r[`IRQ_BIT(0)];
      timer_one_irq  <= tf_r[1] && interrupt_mask_register_r[`IRQ_BIT(1)];
      irq <= (tf_r[0] && interrupt_mask_register_r[`IRQ_BIT(0)]) ||
             (tf_r[1] && interrupt_mask_register_r[`IRQ_BIT(1)]);
    end
  end

  // read decode
  always_comb begin
    rd_byte = 8'h00;
    mapped  = 1'b1;
    unique case (paddr)
      `OFF_CTRL: begin
        rd_byte[`CTRL_TF(1)] = tf_r[1];
        rd_byte[`CTRL_TR(1)] = tr_r[1];
        rd_byte[`CTRL_TF(0)] = tf_r[0];
        rd_byte[`CTRL_TR(0)] = tr_r[0];
      end
      `OFF_MODE:   rd_byte = timer_mode_register_r;
      `OFF_CLKC:   rd_byte = clock_control_register_r;
      `OFF_IMASK:  rd_byte = interrupt_mask_register_r;
      `OFF_EXTCFG: rd_byte = ext_irq_config_register_r;
      `OFF_TL0:    rd_byte = tl_r[0];
      `OFF_TH0:    rd_byte = th_r[0];
      `OFF_TL1:    rd_byte = tl_r[1];
      `OFF_TH1:    rd_byte = th_r[1];
      `OFF_ISTAT: begin
        rd_byte[`IRQ_BIT(0)] = tf_r[0];
        rd_byte[`IRQ_BIT(1)] = tf_r[1];
      end
      `OFF_ICLR:   rd_byte = 8'h00;
      default:     mapped = 1'b0;
    endcase
  end

  // one wait state: ready comes in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !mapped;
      if (psel && penable && !pready_r && !pwrite) begin
        prdata_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign pready  = pready_r;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_flag_on_ovf: assert property (ovf[0] |=> tf_r[0])
    else $error("overflow did not set timer zero flag");
  a_flag_one_ovf: assert property (ovf[1] |=> tf_r[1])
    else $error("overflow did not set timer one flag");
  a_hold_no_run: assert property ((!g_tmr[0].run_ok && !wr)
      |=> $stable(tl_r[0]) && $stable(th_r[0]))
    else $error("timer zero moved while stopped");
  a_reload_copy: assert property ((ovf[0] && g_tmr[0].md == MODE_8RELOAD
      && !wr) |=> tl_r[0] == $past(th_r[0]) && $stable(th_r[0]))
    else $error("reload did not copy high byte");
  a_count_16: assert property ((adv[0] && g_tmr[0].md == MODE_16BIT
      && !wr) |=> {th_r[0], tl_r[0]} == $past({th_r[0], tl_r[0]}) + 16'h0001)
    else $error("16-bit count did not step by one");
  a_count_13: assert property ((adv[1] && g_tmr[1].md == MODE_13BIT
      && !wr) |=> tl_r[1][7:5] == $past(tl_r[1][7:5]))
    else $error("13-bit count touched upper low bits");
  a_sysclk_run: assert property ((tr_r[0] && timer_mode_register_r[3:0]
      == 4'h1 && clock_control_register_r[`CLK_SYS(0)] && !wr)
      |=> tl_r[0] != $past(tl_r[0]))
    else $error("system clock tick did not advance");
  a_edge_count: assert property ((g_tmr[0].ev_fall && g_tmr[0].run_ok
      && timer_mode_register_r[`MODE_CT(0)]) |-> adv[0] || g_tmr[0].md
      == MODE_SPLIT)
    else $error("pin edge not counted");
  a_irq_gate: assert property ((tf_r[0] && !interrupt_mask_register_r[1]
      && !tf_r[1]) |=> !irq)
    else $error("masked overflow raised interrupt");
  a_irq_on: assert property ((tf_r[0] && interrupt_mask_register_r[1])
      |=> irq ##0 timer_zero_irq)
    else $error("enabled overflow did not interrupt");
  a_ack_clear: assert property ((ack[0] && !ovf[0]) |=> !tf_r[0])
    else $error("acknowledge did not clear flag");
  a_run_keeps: assert property (($rose(tr_r[0]) && !wr && !adv[0])
      |-> $stable(tl_r[0]))
    else $error("starting the timer changed the count");

  c_ovf_13: cover property (ovf[1] && g_tmr[1].md == MODE_13BIT);
  c_reload: cover property (ovf[0] && g_tmr[0].md == MODE_8RELOAD);
  c_gated: cover property (tr_r[0] && !g_tmr[0].run_ok ##1 adv[0]);
  c_irq: cover property ($rose(irq));

endmodule : timer_pair

//--- pin_partner.sv
// pin model: falling-edge event pulses and gate levels for the timer pair
// assumes the bench raises go for one pclk cycle while busy is low
`timescale 1ns/1ns

module pin_partner (
  // clock and commands
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic       which,
  input  wire logic [7:0] pulses,
  input  wire logic [1:0] gate_lvl,
  // pins
  output logic            timer_zero_event_pin,
  output logic            timer_one_event_pin,
  output logic            ext_irq_zero_pin,
  output logic            ext_irq_one_pin,
  output logic            busy
);
  logic [7:0] left_r = 8'h00;
  logic       lvl_r  = 1'b1;
  logic       hold_r = 1'b0;
  logic       sel_r  = 1'b0;

  assign busy = (left_r != 8'h00);
  // idle high, so no stray falling edge between bursts
  assign timer_zero_event_pin = sel_r ? 1'b1 : lvl_r;
  assign timer_one_event_pin  = sel_r ? lvl_r : 1'b1;
  assign ext_irq_zero_pin     = gate_lvl[0];
  assign ext_irq_one_pin      = gate_lvl[1];

  // each level held two cycles: the fastest legal event rate
  always @(posedge pclk) begin
    if (go && !busy) begin
      left_r <= pulses;
      sel_r  <= which;
      hold_r <= 1'b0;
    end else if (busy) begin
      hold_r <= !hold_r;
      if (hold_r) begin
        lvl_r <= !lvl_r;
        if (!lvl_r)
          left_r <= left_r - 8'h01;
      end
    end
  end
endmodule : pin_partner

//--- test_dual_counter_timer_modes_0_to_2.sv
// self-checking bench for the counter/timer pair
// assumes the pin model drives the event and gate pins
`timescale 1ns/1ns
`include "timer_pair_defines.svh"

module test_dual_counter_timer_modes_0_to_2
  import timer_pair_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic        ev0, ev1, gi0, gi1, ack0, ack1, irq0, irq1, irq, err_v;
  logic        ev_go, ev_sel, ev_busy;
  logic [7:0]  ev_num;
  logic [1:0]  gate_lvl;
  int          error_cnt, n_checks, cyc;

  timer_pair u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer_zero_event_pin(ev0), .timer_one_event_pin(ev1),
    .ext_irq_zero_pin(gi0), .ext_irq_one_pin(gi1),
    .timer_zero_irq_ack(ack0), .timer_one_irq_ack(ack1),
    .timer_zero_irq(irq0), .timer_one_irq(irq1), .irq(irq));

  pin_partner u_pins (.pclk(pclk), .go(ev_go), .which(ev_sel),
    .pulses(ev_num), .gate_lvl(gate_lvl), .timer_zero_event_pin(ev0),
    .timer_one_event_pin(ev1), .ext_irq_zero_pin(gi0),
    .ext_irq_one_pin(gi1), .busy(ev_busy));

  always #20 pclk = !pclk;

  task automatic stop_test();
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // hang guard, far above the roughly one thousand cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v  = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask : rd

  task automatic wait_flag(input int b);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 100 && !hit; i++) begin
      rd(`OFF_ISTAT);
      hit = rd_v[b];
    end
    chk(hit, 32'h1);
  endtask : wait_flag

  task automatic send(input logic which, input logic [7:0] n);
    ev_go  <= 1'b1;
    ev_sel <= which;
    ev_num <= n;
    @(posedge pclk);
    ev_go <= 1'b0;
    @(posedge pclk);
    while (ev_busy) @(posedge pclk);
    // pin to count takes three edges
    repeat (6) @(posedge pclk);
  endtask : send

  task automatic t_reset_map();
    rd(`OFF_CTRL);
    chk(rd_v, 32'h0);
    rd(8'h30);
    chk({rd_v[7:0], 7'h00, err_v}, 32'h1);
  endtask : t_reset_map

  task automatic t_16bit();
    wr(`OFF_TL0, 8'hFE);
    wr(`OFF_TH0, 8'hFF);
    rd(`OFF_TL0);
    chk(rd_v, 32'hFE);
    wr(`OFF_MODE, {6'h00, MODE_16BIT});
    wr(`OFF_CLKC, 8'h08);
    wr(`OFF_IMASK, 8'h02);
    wr(`OFF_CTRL, 8'h10);
    wait_flag(1);
    chk({irq0, irq}, 32'h3);
    wr(`OFF_CTRL, 8'h20);
    rd(`OFF_TH0);
    chk(rd_v, 32'h0);
    ack0 <= 1'b1;
    @(posedge pclk);
    ack0 <= 1'b0;
    @(posedge pclk);
    rd(`OFF_ISTAT);
    chk(rd_v, 32'h0);
    chk(irq, 32'h0);
  endtask : t_16bit

  task automatic t_13bit();
    wr(`OFF_TH1, 8'hFF);
    wr(`OFF_TL1, 8'h1E);
    wr(`OFF_MODE, 8'h00);
    wr(`OFF_CLKC, 8'h10);
    wr(`OFF_IMASK, 8'h00);
    wr(`OFF_CTRL, 8'h40);
    wait_flag(3);
    wr(`OFF_CTRL, 8'h80);
    rd(`OFF_TH1);
    chk(rd_v, 32'h0);
    chk(irq1, 32'h0);
    wr(`OFF_IMASK, 8'h08);
    // irq outputs lag the enable by one edge
    @(posedge pclk);
    chk({irq1, irq}, 32'h3);
    wr(`OFF_ICLR, 8'h08);
    rd(`OFF_CTRL);
    chk(rd_v, 32'h0);
    chk(irq1, 32'h0);
  endtask : t_13bit

  task automatic t_reload();
    wr(`OFF_TH0, 8'hF0);
    wr(`OFF_TL0, 8'hFE);
    wr(`OFF_TL1, 8'h55);
    wr(`OFF_MODE, 8'h32);
    wr(`OFF_CLKC, 8'h18);
    wr(`OFF_CTRL, 8'h50);
    wait_flag(1);
    wr(`OFF_CTRL, 8'h00);
    rd(`OFF_TH0);
    chk(rd_v, 32'hF0);
    rd(`OFF_TL0);
    chk(rd_v[7:0] >= 8'hF0, 32'h1);
    rd(`OFF_TL1);
    chk(rd_v, 32'h55);
    wr(`OFF_ICLR, 8'h02);
  endtask : t_reload

  task automatic t_counter();
    wr(`OFF_TL0, 8'h00);
    wr(`OFF_TH0, 8'h00);
    wr(`OFF_TL1, 8'h00);
    wr(`OFF_EXTCFG, 8'h08);
    wr(`OFF_MODE, 8'hDD);
    gate_lvl <= 2'b10;
    wr(`OFF_CTRL, 8'h50);
    send(1'b0, 8'h05);
    send(1'b1, 8'h05);
    rd(`OFF_TL0);
    chk(rd_v, 32'h0);
    rd(`OFF_TL1);
    chk(rd_v, 32'h0);
    gate_lvl <= 2'b01;
    repeat (3) @(posedge pclk);
    send(1'b0, 8'h05);
    send(1'b1, 8'h03);
    rd(`OFF_TL0);
    chk(rd_v, 32'h5);
    rd(`OFF_TL1);
    chk(rd_v, 32'h3);
    wr(`OFF_CTRL, 8'h00);
  endtask : t_counter

  task automatic t_scale();
    int dv [5] = '{12, 4, 48, 8, 1};
    int d;
    for (int i = 0; i < 5; i++) begin
      wr(`OFF_TL0, 8'h00);
      wr(`OFF_TH0, 8'h00);
      wr(`OFF_MODE, 8'h01);
      wr(`OFF_CLKC, (i < 4) ? 8'(i) : 8'h08);
      wr(`OFF_CTRL, 8'h10);
      repeat (96) @(posedge pclk);
      wr(`OFF_CTRL, 8'h00);
      rd(`OFF_TL0);
      // start and stop land a few edges apart from the wait
      d = int'(rd_v[7:0]) - 99 / dv[i];
      chk(d >= -3 && d <= 3, 32'h1);
    end
  endtask : t_scale

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, ack0, ack1, ev_go, ev_sel} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ev_num = 8'h00;
    gate_lvl = 2'b00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_map();
    t_16bit();
    t_13bit();
    t_reload();
    t_counter();
    t_scale();
    stop_test();
  end
endmodule : test_dual_counter_timer_modes_0_to_2
